// *** hdl/link_error_routing_pkg.sv ***
// Package for the link error routing register bank.
// Assumes APB access with 32-bit words; printed offsets are word indexes.
package link_error_routing_pkg;

  // Register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_ERROR_ROUTING = 8'h12;
  localparam logic [7:0] IDX_BASE_UPPER    = 8'h14;
  localparam logic [7:0] IDX_LIMIT_UPPER   = 8'h15;
  localparam logic [7:0] IDX_BUS_NUMBER    = 8'h1A;
  localparam logic [7:0] IDX_LINK_LOG      = 8'h20;
  localparam logic [7:0] IDX_STRAPS        = 8'h21;

  // Error routing control fields
  localparam int B_PROT_FLOOD     = 0;
  localparam int B_OVFL_FLOOD     = 1;
  localparam int B_FATAL_LO       = 2;
  localparam int B_CHAIN_FAIL     = 8;
  localparam int B_RESP_ERR       = 9;
  localparam int B_NONFATAL_LO    = 10;

  // Link error log fields
  localparam int B_LOG_PROT       = 4;
  localparam int B_LOG_OVFL       = 5;
  localparam int B_LOG_EOC        = 6;

  // Error source order within each six-bit routing group
  localparam int N_SRC            = 6;
  localparam int S_PROT           = 0;
  localparam int S_OVFL           = 1;
  localparam int S_EOC            = 2;
  localparam int S_RESP           = 3;
  localparam int S_CRC            = 4;
  localparam int S_SYS            = 5;

  localparam logic [15:0] ROUTING_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  // Event inputs from link logic
  typedef struct packed {
    logic prot;
    logic ovfl;
    logic eoc;
    logic resp;
    logic crc;
    logic sys;
  } err_evt_t;

  // Whole register state
  typedef struct packed {
    logic [1:0]   flood_en;
    logic [5:0]   fatal_en;
    logic [5:0]   nonfatal_en;
    logic         chain_fail;
    logic         resp_err;
    logic [2:0]   link_log;
    logic [7:0]   base_upper;
    logic [7:0]   limit_upper;
    logic [7:0]   bus_number;
    logic         flood;
    logic [31:0]  prdata;
    logic         pready;
  } reg_state_t;

endpackage

// *** hdl/link_error_routing_regs.sv ***
// Error routing, chain status, memory extension and bus number registers.
// Assumes synchronous event pulses from link logic on pclk and an APB master.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

// Behaviour
// - Protocol error log floods link when enabled, slave also needs system error report.
// - Overflow error log floods link when enabled, slave also needs system error report.
// - Chain reset leaves both flood enables unchanged.
// - Protocol log with its fatal enable raises fatal interrupt.
// - Overflow log with its fatal enable raises fatal interrupt.
// - End-of-chain log, or inbound flag in a host only, with enable raises fatal interrupt.
// - Response error bit 9 with its enable raises fatal interrupt.
// - Any CRC error flag with its enable raises fatal interrupt.
// - System error fatal enable host-only; secondary system error raises fatal.
// - Bits 10 to 15 route same six errors to nonfatal interrupt.
// - Chain fail sets on flooding or flood cause; chain reset clears it.
// - Response error sets on received error, clears on read, cold reset.
// - Unchecked error conditions have log and enable bits tied zero.
// - Missing interrupt makes its enables read zero and ignore writes.
// - In a host the routing register exists only with extended set.
// - Read-write upper 8 bits of memory base, warm reset clears.
// - Read-write upper 8 bits of memory limit, warm reset clears.
// - With 64-bit remapping both extensions are reserved.
// - Shared primary interface: base and limit values apply to all bridges.
// - Non-host bus number captured from type 0 writes, warm reset clears.
// - Link log bits 4 to 6 clear on read, cold reset only.
module link_error_routing_regs
  import link_error_routing_pkg::*;
#(
  parameter bit         IS_HOST        = 1'b0,
  parameter bit         EXT_REG_SET    = 1'b1,
  parameter bit         HAS_FATAL      = 1'b1,
  parameter bit         HAS_NONFATAL   = 1'b1,
  parameter bit         HAS_REMAP64    = 1'b0,
  parameter bit         HAS_BUS_NUMBER = 1'b1,
  parameter logic [5:0] CHECKED        = 6'h3F
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cold_resetn,
  input  wire logic        chain_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire err_evt_t    err_evt,
  input  wire logic        crc_error_flag,
  input  wire logic        inbound_eoc_flag,
  input  wire logic        sec_system_error,
  input  wire logic        system_error_report,
  input  wire logic        sync_flood_seen,
  input  wire logic        cfg0_write,
  input  wire logic [7:0]  cfg0_bus,
  output logic             flood,
  output logic             fatal_irq,
  output logic             nonfatal_irq,
  output logic      [7:0]  base_upper,
  output logic      [7:0]  limit_upper
);

  ////////////////////////////////////////////////////////////////////////////
  // State and decode
  reg_state_t st;
  reg_state_t next_st;
  logic       resp_err_q;
  logic [2:0] link_log_q;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    return a[11:2] == {2'b00, idx};
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic       routing_present;
  logic       ext_present;
  logic [5:0] cond;
  logic [5:0] fatal_mask;
  logic [5:0] nonfatal_mask;
  logic       flood_cause;
  logic [15:0] routing_word;

  // Host needs the extended set
  // routing presence gate
  assign routing_present = !IS_HOST || EXT_REG_SET;
  assign ext_present     = routing_present && !HAS_REMAP64;

  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  assign fatal_mask    = HAS_FATAL ? (CHECKED & {IS_HOST, 5'h1F}) : 6'h00;
  assign nonfatal_mask = HAS_NONFATAL ? (CHECKED & {IS_HOST, 5'h1F}) : 6'h00;

  // Condition vector per source
  always_comb begin
    cond         = 6'h00;
    cond[S_PROT] = st.link_log[0];
    cond[S_OVFL] = st.link_log[1];
    cond[S_EOC]  = st.link_log[2] || (IS_HOST && inbound_eoc_flag);
    cond[S_RESP] = st.resp_err;
    cond[S_CRC]  = crc_error_flag;
    cond[S_SYS]  = sec_system_error;
    cond         = cond & CHECKED;
  end

  assign flood_cause = routing_present && (IS_HOST || system_error_report) &&
                       ((st.flood_en[0] && st.link_log[0]) ||
                        (st.flood_en[1] && st.link_log[1]));

  assign routing_word = {st.nonfatal_en, st.resp_err, st.chain_fail,
                         st.fatal_en, st.flood_en};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st        = st;
    next_st.pready = 1'b0;
    next_st.prdata = WORD_ZERO;
    next_st.flood  = flood_cause;
    // Writes land at the completing edge
    if (wr && st.pready) begin
      if (hit(paddr, IDX_ERROR_ROUTING) && routing_present) begin
        if (pstrb[0]) begin
          next_st.flood_en = pwdata[1:0] & CHECKED[1:0];
          next_st.fatal_en = pwdata[7:2] & fatal_mask;
        end
        if (pstrb[1]) begin
          next_st.nonfatal_en = pwdata[15:10] & nonfatal_mask;
        end
      end
      if (hit(paddr, IDX_BASE_UPPER) && ext_present && pstrb[0]) begin
        next_st.base_upper = pwdata[7:0];
      end
      if (hit(paddr, IDX_LIMIT_UPPER) && ext_present && pstrb[0]) begin
        next_st.limit_upper = pwdata[7:0];
      end
    end
    if (rd && !st.pready) begin
      next_st.pready = 1'b1;
      unique case (1'b1)
        hit(paddr, IDX_ERROR_ROUTING):
          next_st.prdata = routing_present ? {16'h0000, routing_word} : WORD_ZERO;
        hit(paddr, IDX_BASE_UPPER):
          next_st.prdata = ext_present ? {24'h000000, st.base_upper} : WORD_ZERO;
        hit(paddr, IDX_LIMIT_UPPER):
          next_st.prdata = ext_present ? {24'h000000, st.limit_upper} : WORD_ZERO;
        hit(paddr, IDX_BUS_NUMBER):
          next_st.prdata = {24'h000000, st.bus_number};
        hit(paddr, IDX_LINK_LOG):
          next_st.prdata = {25'h0, st.link_log, 4'h0};
        hit(paddr, IDX_STRAPS):
          next_st.prdata = {26'h0, HAS_REMAP64, HAS_NONFATAL, HAS_FATAL,
                            EXT_REG_SET, IS_HOST, system_error_report};
        default:
          next_st.prdata = WORD_ZERO;
      endcase
    end else if (wr && !st.pready) begin
      next_st.pready = 1'b1;
    end
    if (flood_cause || sync_flood_seen) begin
      next_st.chain_fail = 1'b1;
    end else if (chain_reset) begin
      next_st.chain_fail = 1'b0;
    end
    if (!IS_HOST && HAS_BUS_NUMBER && cfg0_write) begin
      next_st.bus_number = cfg0_bus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cold-reset clear-on-read flags, set wins over read clear
  logic rd_routing;
  logic rd_log;
  assign rd_routing = rd && !st.pready && hit(paddr, IDX_ERROR_ROUTING);
  assign rd_log     = rd && !st.pready && hit(paddr, IDX_LINK_LOG);

  always_ff @(posedge pclk or negedge cold_resetn) begin
    if (!cold_resetn) begin
      resp_err_q <= 1'b0;
      link_log_q <= 3'b000;
    end else begin
      resp_err_q <= CHECKED[S_RESP] &&
                    (err_evt.resp || (resp_err_q && !rd_routing));
      link_log_q <= CHECKED[2:0] & ({err_evt.eoc, err_evt.ovfl, err_evt.prot} |
                                    (rd_log ? 3'b000 : link_log_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warm-reset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st             <= '0;
      st.flood_en    <= ROUTING_RESET[1:0];
      st.base_upper  <= BYTE_RESET;
      st.limit_upper <= BYTE_RESET;
      st.bus_number  <= BYTE_RESET;
    end else begin
      st          <= next_st;
      st.resp_err <= resp_err_q;
      st.link_log <= link_log_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = 1'b0;
  assign flood       = st.flood;
  assign base_upper  = st.base_upper;
  assign limit_upper = st.limit_upper;
  assign fatal_irq    = |(st.fatal_en & cond);
  assign nonfatal_irq = |(st.nonfatal_en & cond);

endmodule // link_error_routing_regs

// *** tb/link_error_routing_regs_monitor.sv ***
// Port checker for the link error routing register bank.
// Assumes full-word APB writes; routing enables are shadowed from them.
`timescale 1ns/1ps
module link_error_routing_regs_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        flood,
  input wire logic        fatal_irq,
  input wire logic        nonfatal_irq,
  input wire logic        crc_error_flag,
  input wire logic        system_error_report,
  input wire logic [7:0]  base_upper,
  input wire logic [7:0]  limit_upper
);
  logic [15:0] en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en <= 16'h0000;
    else if (psel && penable && pready && pwrite && paddr == 12'h048) en <= pwdata[15:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_crc_fatal: assert property ((en[6] && crc_error_flag) [*3] |-> fatal_irq)
    else $error("crc error not routed to fatal");
  a_crc_nonfatal: assert property ((en[14] && crc_error_flag) [*3] |-> nonfatal_irq)
    else $error("crc error not routed to nonfatal");
  a_irq_off: assert property (en == 16'h0000 && !(psel && penable) |-> !fatal_irq && !nonfatal_irq)
    else $error("interrupt without any enable");
  a_flood_gate: assert property ((!system_error_report) [*3] |-> !flood)
    else $error("flood without system error report");
  a_flood_off: assert property ((en[1:0] == 2'b00) [*3] |-> !flood)
    else $error("flood without flood enable");
  a_base_write: assert property (psel && penable && pready && pwrite && paddr == 12'h050
    |=> base_upper == $past(pwdata[7:0]))
    else $error("base extension not written");
  a_limit_write: assert property (psel && penable && pready && pwrite && paddr == 12'h054
    |=> limit_upper == $past(pwdata[7:0]))
    else $error("limit extension not written");
  a_ext_hold: assert property (!(psel && pwrite) |=> $stable(base_upper) && $stable(limit_upper))
    else $error("extension changed without write");
  a_unmapped_zero: assert property (psel && penable && pready && !pwrite && paddr == 12'h0FC
    |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // link_error_routing_regs_monitor
bind link_error_routing_regs link_error_routing_regs_monitor u_link_error_routing_regs_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .flood(flood),
  .fatal_irq(fatal_irq), .nonfatal_irq(nonfatal_irq), .crc_error_flag(crc_error_flag),
  .system_error_report(system_error_report), .base_upper(base_upper), .limit_upper(limit_upper)
);

// *** tb/link_peer_model.sv ***
// Peer node model: raises link error events, level flags and config writes.
// Assumes the bench calls its tasks; all changes land on rising edges.
`timescale 1ns/1ps
module link_peer_model
  import link_error_routing_pkg::*;
(
  input  wire logic       pclk,
  output err_evt_t        err_evt,
  output logic            crc_error_flag,
  output logic            sec_system_error,
  output logic            sync_flood_seen,
  output logic            cfg0_write,
  output logic      [7:0] cfg0_bus
);
  initial begin
    err_evt = '0;
    {crc_error_flag, sec_system_error, sync_flood_seen, cfg0_write} = 4'h0;
    cfg0_bus = 8'h00;
  end
  task automatic evt(input int s);
    @(posedge pclk);
    err_evt <= err_evt_t'(6'h20 >> s);
    @(posedge pclk);
    err_evt <= '0;
  endtask
  task automatic lvl(input logic [2:0] v);
    @(posedge pclk);
    {crc_error_flag, sec_system_error, sync_flood_seen} <= v;
  endtask
  // Bus lines show the inverse once the write is over
  task automatic cfg(input logic [7:0] b);
    @(posedge pclk);
    {cfg0_write, cfg0_bus} <= {1'b1, b};
    @(posedge pclk);
    {cfg0_write, cfg0_bus} <= {1'b0, ~b};
  endtask
endmodule // link_peer_model

// *** tb/tb.sv ***
// Testbench for the link error routing register bank, slave build.
// Assumes an APB master here and the peer model on the link side.
`timescale 1ns/1ps
module tb
  import link_error_routing_pkg::*;
;
  logic        pclk, presetn, chain_reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        system_error_report, flood, fatal_irq, nonfatal_irq, cfg0_write;
  logic        crc_error_flag, sec_system_error, sync_flood_seen, inbound_eoc_flag;
  logic [7:0]  base_upper, limit_upper, cfg0_bus;
  err_evt_t    err_evt;
  int          bad_count, samples_checked;
  link_error_routing_regs u_link_error_routing_regs (
    .pclk(pclk), .presetn(presetn), .cold_resetn(presetn), .chain_reset(chain_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_evt(err_evt),
    .crc_error_flag(crc_error_flag), .inbound_eoc_flag(inbound_eoc_flag),
    .sec_system_error(sec_system_error), .system_error_report(system_error_report),
    .sync_flood_seen(sync_flood_seen), .cfg0_write(cfg0_write), .cfg0_bus(cfg0_bus),
    .flood(flood), .fatal_irq(fatal_irq), .nonfatal_irq(nonfatal_irq),
    .base_upper(base_upper), .limit_upper(limit_upper));
  link_peer_model u_link_peer_model (
    .pclk(pclk), .err_evt(err_evt), .crc_error_flag(crc_error_flag),
    .sec_system_error(sec_system_error), .sync_flood_seen(sync_flood_seen),
    .cfg0_write(cfg0_write), .cfg0_bus(cfg0_bus));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    if (n >= 20) begin
      bad_count++;
      $display("ERROR %0t no bus answer", $time);
    end
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, WORD_ZERO);
    chk(r, e);
  endtask
  task automatic t_regs();
    rd(12'h048, WORD_ZERO);
    rd(12'h050, WORD_ZERO);
    wr(12'h048, 32'h0000_FFFF);
    rd(12'h048, 32'h0000_7C7F);
    wr(12'h050, 32'h0000_00A5);
    wr(12'h054, 32'h0000_005A);
    rd(12'h054, 32'h0000_005A);
    chk({16'h0000, base_upper, limit_upper}, 32'h0000_A55A);
    wr(12'h0FC, 32'hFFFF_FFFF);
    rd(12'h0FC, WORD_ZERO);
    chk({31'h0, pslverr}, WORD_ZERO);
  endtask
  task automatic t_irq();
    wr(12'h048, 32'h0000_C0C0);
    u_link_peer_model.lvl(3'b010);
    repeat (3) @(posedge pclk);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h0);
    u_link_peer_model.lvl(3'b100);
    repeat (3) @(posedge pclk);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h3);
    wr(12'h048, 32'h0000_2020);
    u_link_peer_model.lvl(3'b000);
    u_link_peer_model.evt(S_RESP);
    repeat (3) @(posedge pclk);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h3);
    rd(12'h048, 32'h0000_2220);
    rd(12'h048, 32'h0000_2020);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h0);
    wr(12'h048, 32'h0000_1010);
    inbound_eoc_flag <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h0);
    u_link_peer_model.evt(S_EOC);
    repeat (3) @(posedge pclk);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h3);
    inbound_eoc_flag <= 1'b0;
    rd(12'h080, 32'h0000_0040);
    rd(12'h080, WORD_ZERO);
    chk({30'h0, fatal_irq, nonfatal_irq}, 32'h0);
  endtask
  task automatic t_flood();
    system_error_report <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(12'h048, 32'h0000_0405 << i);
      u_link_peer_model.evt(i);
      repeat (4) @(posedge pclk);
      chk({31'h0, flood}, 32'h1);
      chk({30'h0, fatal_irq, nonfatal_irq}, 32'h3);
      rd(12'h048, 32'h0000_0100 | (32'h0000_0405 << i));
      rd(12'h080, 32'h10 << i);
      rd(12'h080, WORD_ZERO);
      chain_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      chain_reset <= 1'b0;
      rd(12'h048, 32'h0000_0405 << i);
    end
    u_link_peer_model.lvl(3'b001);
    rd(12'h048, 32'h0000_090A);
    u_link_peer_model.lvl(3'b000);
    u_link_peer_model.cfg(8'h3C);
    rd(12'h068, 32'h0000_003C);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {presetn, chain_reset, psel, penable, pwrite, system_error_report, inbound_eoc_flag} = 7'h00;
    {paddr, pwdata, pstrb} = {12'h000, WORD_ZERO, 4'hF};
    {bad_count, samples_checked} = {32'd0, 32'd0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_irq();
    t_flood();
    results();
  end
  initial begin
    #50000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
endmodule // tb
